// *** pkg/sbpc_pkg.sv ***
// constants for the serial baud and clock configuration block
package sbpc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_BAUD      = 8'h3B;
  localparam logic [7:0]  IDX_TRIM      = 8'h3C;
  localparam logic [7:0]  IDX_PLLC      = 8'h3D;
  localparam logic [7:0]  IDX_PDIV      = 8'h3E;
  localparam int          ADDR_W        = 12;
  localparam logic [7:0]  RST_BAUD      = 8'h7A;
  localparam logic [7:0]  RST_TRIM      = 8'h00;
  localparam logic [7:0]  RST_PLLC      = 8'h00;
  localparam logic [7:0]  RST_PDIV      = 8'h08;
  // field positions
  localparam int          EXP_MSB       = 7;
  localparam int          EXP_LSB       = 5;
  localparam int          MANT_MSB      = 4;
  localparam int          SRC_MSB       = 7;
  localparam int          SRC_LSB       = 4;
  localparam int          PIN_EN_BIT    = 3;
  localparam int          PD_BIT        = 2;
  localparam int          FB_MSB        = 1;
  // baud arithmetic, in crystal cycles
  localparam int          BAUD_DIV_W    = 13;
  localparam logic [12:0] MANT_OFS_LO   = 13'h0001;
  localparam logic [12:0] MANT_OFS_HI   = 13'h0021;
  localparam logic [2:0]  DATA_LAST     = 3'h7;
  // feedback factors
  localparam logic [4:0]  FB_23         = 5'h17;
  localparam logic [4:0]  FB_27         = 5'h1B;
  localparam logic [4:0]  FB_28         = 5'h1C;
  // slow oscillator model: period in pclk cycles is base plus trim
  localparam int          LFO_DIV_W     = 10;
  localparam logic [9:0]  LFO_BASE      = 10'h040;
  // clock pin source codes
  localparam logic [3:0]  SRC_IO        = 4'h0;
  localparam logic [3:0]  SRC_PLL       = 4'h1;
  localparam logic [3:0]  SRC_LOW       = 4'h2;
  localparam logic [3:0]  SRC_HIGH      = 4'h3;
  localparam logic [3:0]  SRC_XT1       = 4'h4;
  localparam logic [3:0]  SRC_XT2       = 4'h5;
  localparam logic [3:0]  SRC_XT4       = 4'h6;
  localparam logic [3:0]  SRC_XT8       = 4'h7;
  localparam logic [3:0]  SRC_TMR0      = 4'h8;
  localparam logic [3:0]  SRC_TMR3      = 4'hB;

  typedef enum logic [3:0] {
    SBPC_IDLE  = 4'b0001,
    SBPC_START = 4'b0010,
    SBPC_DATA  = 4'b0100,
    SBPC_STOP  = 4'b1000
  } sbpc_ser_t;
endpackage : sbpc_pkg

// *** rtl/sbpc_clock_config.sv ***
// serial baud generator, uart framing, pll and clock pin control over apb
`timescale 1ns/100ps
module sbpc_clock_config
  import sbpc_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              xtal_tick,
  input  wire logic              xtal_level,
  input  wire logic              pll_vco_tick,
  input  wire logic [3:0]        timer_overflow,
  input  wire logic              gpio_out,
  input  wire logic              gpio_oe,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic                   serial_tx,
  input  wire logic              serial_rx,
  output logic      [7:0]        rx_data,
  output logic                   rx_valid,
  output logic                   rx_frame_err,
  output logic      [7:0]        osc_trim_value,
  output logic                   lfo_tick,
  output logic                   pll_powerdown,
  output logic      [4:0]        pll_feedback_factor,
  output logic      [7:0]        pll_output_divisor,
  output logic                   clock_output_pin_o,
  output logic                   clock_output_pin_oe
);
  typedef struct packed {
    logic [7:0] baud;
    logic [7:0] trim;
    logic [7:0] pllc;
    logic [7:0] pdiv;
    logic [7:0] baud_act;
    logic [7:0] rdata;
    logic       slverr;
    sbpc_ser_t  tx_st;
    logic [7:0] tx_sh;
    logic [2:0] tx_cnt;
    logic       txd;
    sbpc_ser_t  rx_st;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic       rx_prev;
    logic [7:0] rx_out;
    logic       rx_vld;
    logic       rx_ferr;
    logic       half;
    logic [2:0] xdiv;
    logic       tmr_tog;
    logic       pin;
    logic       pin_oe;
  } sbpc_state_t;

  sbpc_state_t q;
  sbpc_state_t d;

  logic [ADDR_W-1:0]     a_baud;
  logic [ADDR_W-1:0]     a_trim;
  logic [ADDR_W-1:0]     a_pllc;
  logic [ADDR_W-1:0]     a_pdiv;
  logic                  setup;
  logic                  wr;
  logic [BAUD_DIV_W-1:0] baud_div;
  logic [2:0]            bexp;
  logic [BAUD_DIV_W-1:0] bmant;
  logic                  tx_accept;
  logic                  rx_start;
  logic                  tx_tick;
  logic                  rx_mid;
  logic                  s1_tick;
  logic                  pll_low;
  logic [LFO_DIV_W-1:0]  lfo_div;
  logic [3:0]            src;

  assign a_baud = ADDR_W'({IDX_BAUD, 2'b00});
  assign a_trim = ADDR_W'({IDX_TRIM, 2'b00});
  assign a_pllc = ADDR_W'({IDX_PLLC, 2'b00});
  assign a_pdiv = ADDR_W'({IDX_PDIV, 2'b00});
  assign setup  = psel & ~penable;
  assign wr     = psel & penable & pwrite;
  assign src    = q.pllc[SRC_MSB:SRC_LSB];

  always_comb begin
    bexp  = q.baud_act[EXP_MSB:EXP_LSB];
    bmant = BAUD_DIV_W'(q.baud_act[MANT_MSB:0]);
    if (bexp == 3'h0) begin
      baud_div = bmant + MANT_OFS_LO;
    end else begin
      baud_div = (bmant + MANT_OFS_HI) << (bexp - 3'h1);
    end
  end

  assign tx_accept = (q.tx_st == SBPC_IDLE) & tx_valid;
  assign rx_start  = (q.rx_st == SBPC_IDLE) & q.rx_prev & ~serial_rx;
  assign lfo_div   = LFO_BASE + LFO_DIV_W'(q.trim);
  // halving stage after the multiplied vco
  assign s1_tick   = pll_vco_tick & ~q.pllc[PD_BIT] & q.half;

  sbpc_divider #(.W(BAUD_DIV_W)) u_tx_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .en       (xtal_tick),
    .restart  (tx_accept),
    .div      (baud_div),
    .tick     (tx_tick),
    .mid      (),
    .low_half ()
  );

  sbpc_divider #(.W(BAUD_DIV_W)) u_rx_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .en       (xtal_tick),
    .restart  (rx_start),
    .div      (baud_div),
    .tick     (),
    .mid      (rx_mid),
    .low_half ()
  );

  sbpc_divider #(.W(LFO_DIV_W)) u_lfo_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .en       (1'b1),
    .restart  (1'b0),
    .div      (lfo_div),
    .tick     (lfo_tick),
    .mid      (),
    .low_half ()
  );

  // second stage divides by the output divisor
  sbpc_divider #(.W(8)) u_pll_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .en       (s1_tick),
    .restart  (q.pllc[PD_BIT]),
    .div      (q.pdiv),
    .tick     (),
    .mid      (),
    .low_half (pll_low)
  );

  always_comb begin
    d        = q;
    d.rx_vld = 1'b0;
    d.rx_prev = serial_rx;
    // apb: read data and error latched in setup, shown in access
    if (setup) begin
      d.slverr = 1'b0;
      d.rdata  = 8'h00;
      if (paddr == a_baud) begin
        d.rdata = q.baud;
      end else if (paddr == a_trim) begin
        d.rdata = q.trim;
      end else if (paddr == a_pllc) begin
        d.rdata = q.pllc;
      end else if (paddr == a_pdiv) begin
        d.rdata = q.pdiv;
      end else begin
        d.slverr = 1'b1;
      end
    end
    // whole-byte fields written at their positions
    if (wr) begin
      if (paddr == a_baud) begin
        d.baud = pwdata[7:0];
      end else if (paddr == a_trim) begin
        d.trim = pwdata[7:0];
      end else if (paddr == a_pllc) begin
        d.pllc = pwdata[7:0];
      end else if (paddr == a_pdiv) begin
        d.pdiv = pwdata[7:0];
      end
    end
    // baud swap only while both directions idle
    if ((q.tx_st == SBPC_IDLE) && (q.rx_st == SBPC_IDLE)) begin
      d.baud_act = q.baud;
    end
    // transmit start, eight data lsb first, stop
    case (q.tx_st)
      SBPC_IDLE: begin
        d.txd = 1'b1;
        if (tx_valid) begin
          d.tx_sh  = tx_data;
          d.tx_cnt = 3'h0;
          d.txd    = 1'b0;
          d.tx_st  = SBPC_START;
        end
      end
      SBPC_START: begin
        if (tx_tick) begin
          d.txd   = q.tx_sh[0];
          d.tx_st = SBPC_DATA;
        end
      end
      SBPC_DATA: begin
        if (tx_tick) begin
          d.tx_sh  = {1'b0, q.tx_sh[7:1]};
          d.tx_cnt = q.tx_cnt + 3'h1;
          d.txd    = q.tx_sh[1];
          if (q.tx_cnt == DATA_LAST) begin
            d.txd   = 1'b1;
            d.tx_st = SBPC_STOP;
          end
        end
      end
      SBPC_STOP: begin
        if (tx_tick) begin
          d.tx_st = SBPC_IDLE;
        end
      end
      default: d.tx_st = SBPC_IDLE;
    endcase
    // receive sampled mid-bit, stop bit checked
    case (q.rx_st)
      SBPC_IDLE: begin
        if (rx_start) begin
          d.rx_st  = SBPC_START;
          d.rx_cnt = 3'h0;
        end
      end
      SBPC_START: begin
        if (rx_mid) begin
          // glitch shorter than half a bit is dropped
          d.rx_st = serial_rx ? SBPC_IDLE : SBPC_DATA;
        end
      end
      SBPC_DATA: begin
        if (rx_mid) begin
          d.rx_sh  = {serial_rx, q.rx_sh[7:1]};
          d.rx_cnt = q.rx_cnt + 3'h1;
          if (q.rx_cnt == DATA_LAST) begin
            d.rx_st = SBPC_STOP;
          end
        end
      end
      SBPC_STOP: begin
        if (rx_mid) begin
          d.rx_out  = q.rx_sh;
          d.rx_vld  = 1'b1;
          d.rx_ferr = ~serial_rx;
          d.rx_st   = SBPC_IDLE;
        end
      end
      default: d.rx_st = SBPC_IDLE;
    endcase
    // divide-by-two flop, cleared while powered down
    if (q.pllc[PD_BIT]) begin
      d.half = 1'b0;
    end else if (pll_vco_tick) begin
      d.half = ~q.half;
    end
    if (xtal_tick) begin
      d.xdiv = q.xdiv + 3'h1;
    end
    if ((src >= SRC_TMR0) && (src <= SRC_TMR3) &&
        timer_overflow[src[1:0]]) begin
      d.tmr_tog = ~q.tmr_tog;
    end
    case (src)
      SRC_IO:   d.pin = gpio_out;
      SRC_PLL:  d.pin = ~q.pllc[PD_BIT] & pll_low;
      SRC_LOW:  d.pin = 1'b0;
      SRC_HIGH: d.pin = 1'b1;
      SRC_XT1:  d.pin = xtal_level;
      SRC_XT2:  d.pin = q.xdiv[0];
      SRC_XT4:  d.pin = q.xdiv[1];
      SRC_XT8:  d.pin = q.xdiv[2];
      4'h8, 4'h9, 4'hA, 4'hB: d.pin = q.tmr_tog;
      default:  d.pin = 1'b0;
    endcase
    d.pin_oe = (src == SRC_IO) ? gpio_oe : q.pllc[PIN_EN_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q          <= '0;
      q.baud     <= RST_BAUD;
      q.baud_act <= RST_BAUD;
      q.trim     <= RST_TRIM;
      q.pllc     <= RST_PLLC;
      q.pdiv     <= RST_PDIV;
      q.tx_st    <= SBPC_IDLE;
      q.rx_st    <= SBPC_IDLE;
      q.txd      <= 1'b1;
      q.rx_prev  <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  always_comb begin
    case (q.pllc[FB_MSB:0])
      2'b01:   pll_feedback_factor = FB_27;
      2'b10:   pll_feedback_factor = FB_28;
      default: pll_feedback_factor = FB_23;
    endcase
  end

  assign prdata              = {24'h000000, q.rdata};
  assign pready              = 1'b1;
  assign pslverr             = psel & penable & q.slverr;
  assign tx_ready            = (q.tx_st == SBPC_IDLE);
  assign serial_tx           = q.txd;
  assign rx_data             = q.rx_out;
  assign rx_valid            = q.rx_vld;
  assign rx_frame_err        = q.rx_ferr;
  assign osc_trim_value      = q.trim;
  assign pll_powerdown       = q.pllc[PD_BIT];
  assign pll_output_divisor  = q.pdiv;
  assign clock_output_pin_o  = q.pin;
  assign clock_output_pin_oe = q.pin_oe;
endmodule : sbpc_clock_config

// *** rtl/sbpc_divider.sv ***
// restartable counter giving period tick, mid-period pulse and first half
`timescale 1ns/100ps
module sbpc_divider #(
  parameter int W = 13
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         en,
  input  wire logic         restart,
  input  wire logic [W-1:0] div,
  output logic              tick,
  output logic              mid,
  output logic              low_half
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } sbpc_div_st_t;

  if (W < 2) begin : g_bad_width
    $error("sbpc_divider width too small");
  end

  sbpc_div_st_t q;
  sbpc_div_st_t d;
  logic [W-1:0] div_eff;
  logic [W-1:0] last;

  always_comb begin
    d        = q;
    // zero divisor behaves as one, counter never wedges
    div_eff  = (div == '0) ? {{(W-1){1'b0}}, 1'b1} : div;
    last     = div_eff - {{(W-1){1'b0}}, 1'b1};
    tick     = en & ~restart & (q.cnt >= last);
    mid      = en & ~restart & (q.cnt == (div_eff >> 1));
    low_half = (q.cnt < (div_eff >> 1));
    if (restart) begin
      d.cnt = '0;
    end else if (en) begin
      d.cnt = (q.cnt >= last) ? '0 : q.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule : sbpc_divider

// *** test/sbpc_checker.sv ***
// port assertions for the serial baud and clock config block
`timescale 1ns/100ps
module sbpc_checker
  import sbpc_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic              serial_tx,
  input wire logic              rx_valid,
  input wire logic [7:0]        osc_trim_value,
  input wire logic              pll_powerdown,
  input wire logic [4:0]        pll_feedback_factor,
  input wire logic [7:0]        pll_output_divisor
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_acc;
  assign wr_acc = ce && psel && penable && pwrite;
  pready_high_a: assert property (pready) else $error("pready low");
  err_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  err_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  trim_write_a: assert property (
    wr_acc && paddr == 12'h0F0 |=> osc_trim_value == $past(pwdata[7:0]))
    else $error("trim not written");
  div_write_a: assert property (
    wr_acc && paddr == 12'h0F8 |=> pll_output_divisor == $past(pwdata[7:0]))
    else $error("divisor not written");
  pd_write_a: assert property (
    wr_acc && paddr == 12'h0F4 |=> pll_powerdown == $past(pwdata[2]))
    else $error("powerdown not written");
  fb_decode_a: assert property (
    wr_acc && paddr == 12'h0F4 |=> pll_feedback_factor ==
    ($past(pwdata[1:0]) == 2'h1 ? FB_27 :
     $past(pwdata[1:0]) == 2'h2 ? FB_28 : FB_23))
    else $error("feedback factor wrong");
  tx_start_a: assert property (
    ce && tx_valid && tx_ready |=> !serial_tx && !tx_ready)
    else $error("no start bit");
  tx_idle_a: assert property (tx_ready |-> serial_tx)
    else $error("line not idle high");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid)
    else $error("rx_valid longer than one cycle");
endmodule : sbpc_checker
bind sbpc_clock_config sbpc_checker u_chk (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .serial_tx(serial_tx),
  .rx_valid(rx_valid), .osc_trim_value(osc_trim_value),
  .pll_powerdown(pll_powerdown), .pll_feedback_factor(pll_feedback_factor),
  .pll_output_divisor(pll_output_divisor));

// *** test/sbpc_clock_config_tb_top.sv ***
// self-checking bench for the serial baud and clock config block
`timescale 1ns/100ps
module sbpc_clock_config_tb_top
  import sbpc_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              err, xt, srx, stx, tx_valid, tx_ready, rx_valid, ferr;
  logic [3:0]        tmr;
  logic [7:0]        tx_data, rx_data, trim, pdiv;
  logic [4:0]        fbf;
  logic              pd, pin_o, pin_oe, ce, vco, low_freq_oscillator;
  logic [1:0]        gpio;
  int                failures = 0;
  int                num_checks = 0;
  sbpc_host_model xm (.pclk(pclk), .xtal_tick(xt), .serial_rx(srx));
  sbpc_clock_config dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_tick(xt), .xtal_level(xt), .pll_vco_tick(vco),
    .timer_overflow(tmr), .gpio_out(gpio[1]), .gpio_oe(gpio[0]),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .serial_tx(stx), .serial_rx(srx), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_frame_err(ferr), .osc_trim_value(trim),
    .lfo_tick(low_freq_oscillator), .pll_powerdown(pd), .pll_feedback_factor(fbf),
    .pll_output_divisor(pdiv), .clock_output_pin_o(pin_o),
    .clock_output_pin_oe(pin_oe));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic int nb(input logic [7:0] c);
    return c[7:5] == 3'h0 ? c[4:0] + 1 : (c[4:0] + 33) << (c[7:5] - 1);
  endfunction : nb
  task automatic send_tx(input logic [7:0] d);
    tx_data <= d;
    tx_valid <= 1'b1;
    do @(posedge pclk); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask : send_tx
  task automatic low_run(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (stx !== 1'b1 && n < 9000);
  endtask : low_run
  task automatic near(input int n, input int e);
    chk({31'h0, n >= e - 2 && n <= e + 2}, 32'h1);
  endtask : near
  task automatic t_regs();
    apb(0, IDX_BAUD, 0);
    chk(rd, 32'h7A);
    apb(0, IDX_PDIV, 0);
    chk(rd, 32'h08);
    apb(1, IDX_TRIM, 8'hC3);
    apb(0, IDX_TRIM, 0);
    chk(rd, 32'hC3);
    chk(trim, 32'hC3);
    // frozen block must ignore the write
    ce <= 1'b0;
    apb(1, IDX_TRIM, 8'h5C);
    ce <= 1'b1;
    apb(0, IDX_TRIM, 0);
    chk(rd, 32'hC3);
    apb(0, 8'h3F, 0);
    chk({rd[30:0], err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1, IDX_PLLC, {5'h0, i[0], i[1:0]});
      chk({fbf, pd}, {i == 1 ? FB_27 : i == 2 ? FB_28 : FB_23, i[0]});
    end
    apb(1, IDX_PDIV, 8'hFE);
    chk(pdiv, 32'hFE);
    $display("register test done");
  endtask : t_regs
  task automatic t_pin();
    apb(1, IDX_PLLC, 8'h38);
    @(posedge pclk);
    chk({pin_o, pin_oe}, 32'h3);
    apb(1, IDX_PLLC, 8'h28);
    @(posedge pclk);
    chk({pin_o, pin_oe}, 32'h1);
    apb(1, IDX_PLLC, 8'h88);
    @(posedge pclk);
    tmr <= 4'h2;
    @(posedge pclk);
    tmr <= 4'h1;
    @(posedge pclk);
    tmr <= 4'h0;
    repeat (2) @(posedge pclk);
    chk({pin_o, pin_oe}, 32'h3);
    gpio <= 2'h3;
    apb(1, IDX_PLLC, 8'h00);
    @(posedge pclk);
    chk({pin_o, pin_oe}, 32'h3);
    gpio <= 2'h0;
    apb(1, IDX_PLLC, 8'h30);
    @(posedge pclk);
    chk(pin_oe, 32'h0);
    $display("pin test done");
  endtask : t_pin
  task automatic rise_count(input int m, output int e);
    logic p;
    e = 0;
    @(posedge pclk);
    p = pin_o;
    repeat (m) begin
      @(posedge pclk);
      if (pin_o === 1'b1 && p === 1'b0) e++;
      p = pin_o;
    end
  endtask : rise_count
  task automatic lfo_gap(output int g);
    g = 0;
    do @(posedge pclk); while (low_freq_oscillator !== 1'b1);
    do begin
      @(posedge pclk);
      g++;
    end while (low_freq_oscillator !== 1'b1 && g < 2000);
  endtask : lfo_gap
  task automatic t_clk();
    int e, g1, g2;
    // crystal pin sources: windows of whole periods
    for (int s = 0; s < 4; s++) begin
      apb(1, IDX_PLLC, {2'h1, s[1:0], 4'h8});
      rise_count(64, e);
      chk(e, 32'd32 >> s);
    end
    apb(1, IDX_PDIV, 8'h08);
    vco <= 1'b1;
    apb(1, IDX_PLLC, 8'h18);
    rise_count(64, e);
    chk(e, 32'd4);
    apb(1, IDX_PLLC, 8'h1C);
    rise_count(16, e);
    chk({e[30:0], pin_o}, 32'h0);
    vco <= 1'b0;
    lfo_gap(g1);
    chk(g1, LFO_BASE + 32'hC3);
    apb(1, IDX_TRIM, 8'h10);
    lfo_gap(g2);
    chk(g2, LFO_BASE + 32'h10);
    chk({31'h0, g2 < g1}, 32'h1);
    $display("clock pin test done");
  endtask : t_clk
  task automatic t_baud();
    int n;
    logic [7:0] c[4] = '{8'h15, 8'h3A, 8'h5A, 8'h7A};
    foreach (c[i]) begin
      apb(1, IDX_BAUD, c[i]);
      send_tx(8'h00);
      low_run(n);
      near(n, 18 * nb(c[i]));
    end
    apb(1, IDX_BAUD, 8'h15);
    send_tx(8'h00);
    fork
      low_run(n);
      begin
        repeat (20) @(posedge pclk);
        apb(1, IDX_BAUD, 8'h3A);
      end
    join
    near(n, 396);
    send_tx(8'h00);
    low_run(n);
    near(n, 1062);
    $display("baud test done");
  endtask : t_baud
  task automatic t_frame();
    apb(1, IDX_BAUD, 8'h15);
    send_tx(8'hA5);
    repeat (22) @(posedge pclk);
    chk(stx, 32'h0);
    for (int k = 0; k < 9; k++) begin
      repeat (44) @(posedge pclk);
      chk(stx, k < 8 ? 8'hA5 >> k & 1 : 1);
    end
    for (int j = 0; j < 2; j++) begin
      fork
        xm.send(8'h5A ^ 8'(j), !j, 22);
        for (int n = 0; n < 600 && rx_valid !== 1'b1; n++) @(posedge pclk);
      join_any
      chk({rx_valid, ferr, rx_data}, {1'b1, j[0], 8'h5A ^ 8'(j)});
      wait fork;
      @(posedge pclk);
    end
    $display("frame test done");
  endtask : t_frame
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (40000) @(posedge pclk);
    failures++;
    $display("Error at %0t: run did not finish", $time);
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite, tx_valid} = 5'h0;
    paddr = '0;
    pwdata = '0;
    tx_data = '0;
    tmr = '0;
    gpio = '0;
    {ce, vco} = 2'b10;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_pin();
    t_clk();
    t_baud();
    t_frame();
    summarize();
  end
endmodule : sbpc_clock_config_tb_top

// *** test/sbpc_host_model.sv ***
// crystal tick source and host side serial transmitter
`timescale 1ns/100ps
module sbpc_host_model #(
  parameter int XT_GAP = 2
) (
  input  wire logic pclk,
  output logic      xtal_tick,
  output logic      serial_rx
);
  int cnt = 0;
  initial begin
    xtal_tick = 1'b0;
    serial_rx = 1'b1;
  end
  // crystal runs free, one pulse every XT_GAP cycles
  always @(posedge pclk) begin
    cnt <= (cnt + 1) % XT_GAP;
    xtal_tick <= (cnt == XT_GAP - 1);
  end
  task automatic send(input logic [7:0] d, input logic stp, input int nb);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rx <= f[i];
      repeat (nb * XT_GAP) @(posedge pclk);
    end
    serial_rx <= 1'b1;
  endtask : send
endmodule : sbpc_host_model
